// ===== include/svm_regs.vh
// register map, field positions, reset values and timing counts
`ifndef SVM_REGS_VH
`define SVM_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define SVM_OFS_CTRL 8'h00
`define SVM_OFS_STATUS 8'h04
`define SVM_OFS_INT_STAT 8'h08
`define SVM_OFS_INT_EN 8'h0C
`define SVM_OFS_INT_CLR 8'h10
`define SVM_OFS_CFG0 8'h40
`define SVM_OFS_CFG_LAST 8'h64
// ****************************************
// field positions
// ****************************************
`define SVM_NCH 10
`define SVM_CTRL_FILT_LSB 0
`define SVM_CTRL_WIN_LSB 16
`define SVM_CFG_A_LSB 0
`define SVM_CFG_B_LSB 16
`define SVM_CFG_FINE_LSB 4
`define SVM_CFG_ZERO_BIT 9
`define SVM_ST_B_LSB 16
`define SVM_ST_READY_BIT 31
`define SVM_INT_CFGERR_BIT 30
`define SVM_VIN_W 13
// ****************************************
// reset values
// ****************************************
`define SVM_CTRL_RST 32'h0000_0000
`define SVM_CFG_RST 32'h0011_0011
`define SVM_INT_EN_RST 32'h0000_0000
// ****************************************
// timing and thresholds
// ****************************************
`define SVM_CLK_MHZ 200
`define SVM_FILT_ON_US 64
`define SVM_FILT_OFF_US 16
`define SVM_CAL_CYC 256
`define SVM_ZERO_MV 13'h004B
`define SVM_ZERO_HYST_MV 13'h0001
`define SVM_COARSE_MAX 4'hC
`define SVM_FINE_MAX 5'h1F
`endif

// ===== logic/svm_monitor.v
// ten-channel supply voltage monitor with apb registers
// How it works
// - ten channels, each with comparators A and B
// - comparator high while input exceeds threshold
// - 370 trip levels, 0.680V to 5.867V
// - coarse 1-12, fine 1-31, no 31 at 5/9
// - optional 75mV zero-detect threshold
// - calibrate and init filters, then raise ready
// - hysteresis about 1% of the setpoint
// - rising output only above upper trip point
// - falling output only below lower trip point
// - A output: filtered A or window B and not A
// - synchronous filter delay 64us on, 16us off
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "svm_regs.vh"
module svm_monitor #(
  parameter FILT_ON_CYC = `SVM_FILT_ON_US * `SVM_CLK_MHZ
) (
  // clock and reset
  input wire i_mclk,
  input wire i_srst,
  // monitored supplies, millivolts, channel n at bits 13n+12:13n
  input wire [`SVM_NCH*`SVM_VIN_W-1:0] i_supply_monitor_input,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // status to logic array
  output reg [`SVM_NCH-1:0] o_channel_status_a,
  output reg [`SVM_NCH-1:0] o_channel_status_b,
  output reg o_analog_calibrated_ready,
  // interrupt
  output reg o_irq
);
  localparam FILT_OFF_CYC = `SVM_FILT_OFF_US * `SVM_CLK_MHZ;
  localparam [13:0] LIM_ON = FILT_ON_CYC;
  localparam [13:0] LIM_OFF = FILT_OFF_CYC;
  localparam [8:0] CAL_LIM = `SVM_CAL_CYC;
  localparam ST_CAL = 1'b0;
  localparam ST_RUN = 1'b1;

  // ****************************************
  // trip table: {fine-1 base, step x10, hysteresis}
  // ****************************************
  function [28:0] svm_tab;
    input [3:0] c;
    begin
      case (c)
        4'h1: svm_tab = {13'd806, 9'd42, 7'd8};
        4'h2: svm_tab = {13'd960, 9'd50, 7'd10};
        4'h3: svm_tab = {13'd1143, 9'd60, 7'd12};
        4'h4: svm_tab = {13'd1360, 9'd71, 7'd14};
        4'h5: svm_tab = {13'd1612, 9'd84, 7'd17};
        4'h6: svm_tab = {13'd1923, 9'd100, 7'd20};
        4'h7: svm_tab = {13'd2290, 9'd119, 7'd24};
        4'h8: svm_tab = {13'd2719, 9'd141, 7'd28};
        4'h9: svm_tab = {13'd3223, 9'd168, 7'd34};
        4'hA: svm_tab = {13'd3839, 9'd200, 7'd40};
        4'hB: svm_tab = {13'd4926, 9'd257, 7'd51};
        default: svm_tab = {13'd5867, 9'd306, 7'd61};
      endcase
    end
  endfunction

  // legal check of one comparator setting
  function svm_bad;
    input [9:0] s;
    begin
      svm_bad = !s[`SVM_CFG_ZERO_BIT] &&
        (s[3:0] == 4'h0 || s[3:0] > `SVM_COARSE_MAX || s[8:4] == 5'h00 ||
         (s[8:4] == `SVM_FINE_MAX && (s[3:0] == 4'h5 || s[3:0] == 4'h9)));
    end
  endfunction

  // upper and lower trip points of one comparator: {utp, ltp}
  function [25:0] svm_trip;
    input [9:0] s;
    reg [3:0] c;
    reg [4:0] f;
    reg [28:0] t;
    reg [13:0] prod;
    reg [12:0] upper_trip_point;
    begin
      c = (s[3:0] == 4'h0 || s[3:0] > `SVM_COARSE_MAX) ? 4'h1 : s[3:0];
      f = (s[8:4] == 5'h00) ? 5'h01 : s[8:4];
      if (f == `SVM_FINE_MAX && (c == 4'h5 || c == 4'h9))
        f = 5'h1E;
      t = svm_tab(c);
      prod = {9'h000, f - 5'h01} * {5'h00, t[15:7]};
      upper_trip_point = t[28:16] - prod[12:0] / 13'd10;
      if (s[`SVM_CFG_ZERO_BIT])
        svm_trip = {`SVM_ZERO_MV, `SVM_ZERO_MV - `SVM_ZERO_HYST_MV};
      else
        svm_trip = {upper_trip_point, upper_trip_point - {6'h00, t[6:0]}};
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] ctrl;
  reg [31:0] int_stat;
  reg [31:0] int_en;
  reg [31:0] cfg_mem [0:`SVM_NCH-1];
  reg state;
  reg [8:0] cal_cnt;
  reg ready_d;
  reg [`SVM_NCH-1:0] raw_a;
  reg [`SVM_NCH-1:0] raw_b;
  reg [`SVM_NCH-1:0] filt_a;
  reg [`SVM_NCH-1:0] filt_b;
  wire [`SVM_NCH-1:0] next_status_a;
  wire [`SVM_NCH-1:0] cfg_err;
  wire [31:0] ev;
  wire acc = i_psel && i_penable && o_pready;
  wire wr = acc && i_pwrite;
  wire in_cfg = i_paddr >= `SVM_OFS_CFG0 && i_paddr <= `SVM_OFS_CFG_LAST &&
    i_paddr[1:0] == 2'b00;
  wire [7:0] cfg_off = i_paddr - `SVM_OFS_CFG0;
  wire [3:0] cfg_idx = cfg_off[5:2];
  reg [31:0] next_rdata;
  reg next_err;

  // ****************************************
  // calibration sequencer
  // ****************************************
  always @(posedge i_mclk) begin
    if (i_srst) begin
      state <= ST_CAL;
      cal_cnt <= 9'h000;
      o_analog_calibrated_ready <= 1'b0;
    end else begin
      case (state)
        ST_CAL: begin
          cal_cnt <= cal_cnt + 9'h001;
          if (cal_cnt == CAL_LIM - 9'h001) begin
            state <= ST_RUN;
            o_analog_calibrated_ready <= 1'b1;
          end
        end
        ST_RUN: o_analog_calibrated_ready <= 1'b1;
        default: state <= ST_CAL;
      endcase
    end
  end

  // ****************************************
  // per-channel comparators and filters
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `SVM_NCH; g = g + 1) begin : g_ch
      wire [12:0] vin = i_supply_monitor_input[g*13 +: 13];
      wire [25:0] ta = svm_trip(cfg_mem[g][`SVM_CFG_A_LSB +: 10]);
      wire [25:0] tb = svm_trip(cfg_mem[g][`SVM_CFG_B_LSB +: 10]);
      wire [13:0] lim = ctrl[`SVM_CTRL_FILT_LSB + g] ? LIM_ON : LIM_OFF;
      reg [13:0] cnt_a;
      reg [13:0] cnt_b;
      assign cfg_err[g] = svm_bad(cfg_mem[g][`SVM_CFG_A_LSB +: 10]) |
        svm_bad(cfg_mem[g][`SVM_CFG_B_LSB +: 10]);
      always @(posedge i_mclk) begin
        if (i_srst || state == ST_CAL) begin
          raw_a[g] <= 1'b0;
          raw_b[g] <= 1'b0;
          filt_a[g] <= 1'b0;
          filt_b[g] <= 1'b0;
          cnt_a <= 14'h0000;
          cnt_b <= 14'h0000;
        end else begin
          // hysteretic compare
          if (!raw_a[g])
            raw_a[g] <= vin > ta[25:13];
          else
            raw_a[g] <= vin >= ta[12:0];
          if (!raw_b[g])
            raw_b[g] <= vin > tb[25:13];
          else
            raw_b[g] <= vin >= tb[12:0];
          // stable-time filter
          if (raw_a[g] == filt_a[g])
            cnt_a <= 14'h0000;
          else if (cnt_a >= lim - 14'h0001) begin
            filt_a[g] <= raw_a[g];
            cnt_a <= 14'h0000;
          end else
            cnt_a <= cnt_a + 14'h0001;
          if (raw_b[g] == filt_b[g])
            cnt_b <= 14'h0000;
          else if (cnt_b >= lim - 14'h0001) begin
            filt_b[g] <= raw_b[g];
            cnt_b <= 14'h0000;
          end else
            cnt_b <= cnt_b + 14'h0001;
        end
      end
      assign next_status_a[g] = ctrl[`SVM_CTRL_WIN_LSB + g] ?
        (filt_b[g] & ~filt_a[g]) : filt_a[g];
    end
  endgenerate

  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_channel_status_a <= {`SVM_NCH{1'b0}};
      o_channel_status_b <= {`SVM_NCH{1'b0}};
      ready_d <= 1'b0;
    end else begin
      o_channel_status_a <= next_status_a;
      o_channel_status_b <= filt_b;
      ready_d <= o_analog_calibrated_ready;
    end
  end

  // ****************************************
  // interrupt events
  // ****************************************
  assign ev = {o_analog_calibrated_ready & ~ready_d, |cfg_err, 4'h0,
    o_channel_status_b ^ filt_b, 6'h00,
    o_channel_status_a ^ next_status_a};

  always @(posedge i_mclk) begin
    if (i_srst) begin
      int_stat <= 32'h0000_0000;
      o_irq <= 1'b0;
    end else begin
      if (wr && i_paddr == `SVM_OFS_INT_CLR)
        int_stat <= (int_stat & ~i_pwdata) | ev;
      else
        int_stat <= int_stat | ev;
      o_irq <= |(int_stat & int_en);
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (in_cfg)
      next_rdata = cfg_mem[cfg_idx];
    else
      case (i_paddr)
        `SVM_OFS_CTRL: next_rdata = ctrl;
        `SVM_OFS_STATUS: next_rdata = {o_analog_calibrated_ready,
          5'h00, o_channel_status_b, 6'h00, o_channel_status_a};
        `SVM_OFS_INT_STAT: next_rdata = int_stat;
        `SVM_OFS_INT_EN: next_rdata = int_en;
        `SVM_OFS_INT_CLR: next_rdata = 32'h0000_0000;
        default: next_err = 1'b1;
      endcase
  end

  integer k;
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      ctrl <= `SVM_CTRL_RST;
      int_en <= `SVM_INT_EN_RST;
      for (k = 0; k < `SVM_NCH; k = k + 1)
        cfg_mem[k] <= `SVM_CFG_RST;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && next_err;
      o_prdata <= (i_psel && i_penable && !o_pready && !i_pwrite) ?
        next_rdata : 32'h0000_0000;
      if (wr && in_cfg)
        cfg_mem[cfg_idx] <= i_pwdata & 32'h03FF_03FF;
      if (wr && i_paddr == `SVM_OFS_CTRL)
        ctrl <= i_pwdata & 32'h03FF_03FF;
      if (wr && i_paddr == `SVM_OFS_INT_EN)
        int_en <= i_pwdata & 32'hC3FF_03FF;
    end
  end
endmodule // svm_monitor
`default_nettype wire

// ===== bench/svm_rails.sv
// model of the ten monitored supply rails
`timescale 1ns/1ps
`default_nettype none
`include "svm_regs.vh"
module svm_rails (
  // rail levels in millivolts
  output var logic [`SVM_NCH*`SVM_VIN_W-1:0] o_rails
);
  // ****************************************
  // rail levels
  // ****************************************
  logic [`SVM_VIN_W-1:0] mv [`SVM_NCH] = '{default: 13'h0000};
  always_comb begin
    for (int i = 0; i < `SVM_NCH; i++) begin
      o_rails[i*`SVM_VIN_W +: `SVM_VIN_W] = mv[i];
    end
  end
  task automatic set_mv(input int ch, input logic [`SVM_VIN_W-1:0] v);
    mv[ch] <= v;
  endtask
endmodule // svm_rails
`default_nettype wire

// ===== bench/svm_monitor_assertions.sv
// port checker for the supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "svm_regs.vh"
module svm_monitor_chk (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [`SVM_NCH-1:0] o_channel_status_a,
  input wire logic [`SVM_NCH-1:0] o_channel_status_b,
  input wire logic o_analog_calibrated_ready
);
  // ****************************************
  // properties
  // ****************************************
  logic [15:0] cnt;
  always_ff @(posedge i_mclk) begin
    if (i_srst) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_done;
    o_pready ##1 !o_pready;
  endsequence
  chk_pready_wait: assert property (s_wait |=> s_done)
    else $error("pready not a single pulse after one wait");
  chk_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error reply without pready or with data");
  chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside the reply cycle");
  chk_ready_hold: assert property (
    o_analog_calibrated_ready |=> o_analog_calibrated_ready)
    else $error("ready fell");
  chk_ready_time: assert property (
    $rose(o_analog_calibrated_ready) |-> cnt == 16'h0100)
    else $error("ready rose at the wrong cycle");
  chk_ready_due: assert property (
    cnt == 16'h0100 |-> o_analog_calibrated_ready)
    else $error("ready missing after calibration");
  chk_status_gate: assert property (!o_analog_calibrated_ready |->
    !(|o_channel_status_a) && !(|o_channel_status_b))
    else $error("status active before ready");
  chk_filter_hold: assert property ($changed(o_channel_status_b[0]) |=>
    $stable(o_channel_status_b[0])[*8])
    else $error("status b toggled faster than the filter");
endmodule // svm_monitor_chk
bind svm_monitor svm_monitor_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_channel_status_a(o_channel_status_a),
  .o_channel_status_b(o_channel_status_b),
  .o_analog_calibrated_ready(o_analog_calibrated_ready));
`default_nettype wire

// ===== bench/test_supply_voltage_monitor_compare.sv
// self-checking bench for the supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "svm_regs.vh"
module test_supply_voltage_monitor_compare;
  // ****************************************
  // bench signals and table
  // ****************************************
  localparam int FILT = 64;
  localparam int OFF = 16 * 200;
  typedef struct packed {
    logic [3:0] ch;
    logic [9:0] cfg;
    logic [12:0] mv;
    logic ex;
  } svm_row_t;
  localparam svm_row_t ROWS [15] = '{
    '{4'h0, 10'h000, 13'h0327, 1'b1}, '{4'h0, 10'h000, 13'h0320, 1'b1},
    '{4'h0, 10'h000, 13'h031D, 1'b0}, '{4'h0, 10'h000, 13'h0325, 1'b0},
    '{4'h1, 10'h01C, 13'h16EC, 1'b1}, '{4'h1, 10'h000, 13'h16AF, 1'b1},
    '{4'h1, 10'h000, 13'h16AD, 1'b0}, '{4'h2, 10'h1E9, 13'h0AB1, 1'b1},
    '{4'h2, 10'h000, 13'h0A8D, 1'b0}, '{4'h3, 10'h211, 13'h004C, 1'b1},
    '{4'h3, 10'h000, 13'h004A, 1'b1}, '{4'h3, 10'h000, 13'h0049, 1'b0},
    '{4'h4, 10'h1F1, 13'h02A8, 1'b0}, '{4'h4, 10'h000, 13'h02A9, 1'b1},
    '{4'h9, 10'h011, 13'h0327, 1'b1}};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic [`SVM_NCH*`SVM_VIN_W-1:0] rails;
  wire logic [31:0] prdata;
  wire logic pready, perr, rdy, irq;
  wire logic [`SVM_NCH-1:0] sa, sb;
  logic [31:0] rd;
  logic er;
  logic [9:0] ev = 10'h000;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  svm_rails u_rails (.o_rails(rails));
  svm_monitor #(.FILT_ON_CYC(FILT)) dut (.i_mclk(clk), .i_srst(srst),
    .i_supply_monitor_input(rails), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(perr), .o_channel_status_a(sa),
    .o_channel_status_b(sb), .o_analog_calibrated_ready(rdy), .o_irq(irq));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic settle(input int ch, input logic [12:0] v, input int n);
    @(posedge clk);
    u_rails.set_mv(ch, v);
    repeat (n) @(posedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdchk(`SVM_OFS_CFG0, `SVM_CFG_RST, "cfg0_reset");
    rdchk(`SVM_OFS_CTRL, `SVM_CTRL_RST, "ctrl_reset");
    rdchk(`SVM_OFS_INT_EN, `SVM_INT_EN_RST, "int_en_reset");
    wait (rdy === 1'b1);
    apb(1'b1, `SVM_OFS_CTRL, 32'h0000_03DF);
    for (int i = 0; i < 15; i++) begin
      if (ROWS[i].cfg != 10'h000) apb(1'b1, `SVM_OFS_CFG0 + {ROWS[i].ch, 2'b00},
        {6'h00, ROWS[i].cfg, 6'h00, ROWS[i].cfg});
      settle(ROWS[i].ch, ROWS[i].mv, FILT + 6);
      ev[ROWS[i].ch] = ROWS[i].ex;
      chk("status_a", {22'h0, ev}, {22'h0, sa});
      chk("status_b", {22'h0, ev}, {22'h0, sb});
    end
    apb(1'b1, `SVM_OFS_CFG0, 32'h0011_0012);
    apb(1'b1, `SVM_OFS_CTRL, 32'h0001_03DF);
    settle(0, 13'h0384, FILT + 6);
    chk("window_in", 32'h3, {30'h0, sb[0], sa[0]});
    settle(0, 13'h03E8, FILT + 6);
    chk("window_high", 32'h2, {30'h0, sb[0], sa[0]});
    apb(1'b0, `SVM_OFS_INT_STAT, 32'h0);
    chk("int_a0", 32'h1, rd & 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, `SVM_OFS_INT_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, `SVM_OFS_INT_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdchk(8'h20, 32'h0, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, `SVM_OFS_CFG0 + 8'h18, 32'h01F5_01F5);
    apb(1'b0, `SVM_OFS_INT_STAT, 32'h0);
    chk("cfg_err", 32'h4000_0000, rd & 32'h4000_0000);
    settle(5, 13'h0384, OFF - 100);
    chk("filter_off_early", 32'h0, {31'h0, sb[5]});
    repeat (200) @(posedge clk);
    chk("filter_off_late", 32'h1, {31'h0, sb[5]});
    wrap_up();
  end
endmodule // test_supply_voltage_monitor_compare
`default_nettype wire
